// ==== rtl/vlca_adjust_regs.sv ====
`timescale 1ns/100ps
// Operation
// - control bytes reset to 0x20
// - bit 7 removes luma notch filter
// - bit 5 bypasses luma decimation
// - bit 4 swaps Cb/Cr sample order
// - luma gain is bit 2 plus low byte
// - luma multiplied by gain, unity 216
// - luma gain low byte resets to 0xD8
// - U gain is bit 1 plus low byte
// - U scaled by gain, unity 254
// - U gain low byte resets to 0xFE
// - bit 0 is V gain top bit
// - V scaled by gain, unity 180
module vlca_adjust_regs
  import vlca_pkg::*;
(
  input  wire logic                   clk_i,
  input  wire logic                   reset_i,
  input  wire vlca_pkg::vlca_bus_req_t bus_i,
  output logic      [7:0]             rdata_o,
  input  wire logic                   odd_field_i,
  input  wire logic [7:0]             v_gain_low_byte_i,
  input  wire logic                   pix_valid_i,
  input  wire vlca_pkg::vlca_pixel_t  pix_i,
  output logic                        pix_valid_o,
  output vlca_pkg::vlca_pixel_t       pix_o,
  output vlca_pkg::vlca_ctrl_t        ctrl_o
);
  import vlca_pkg::*;

  logic [7:0] ctrl_even_r;
  logic [7:0] ctrl_odd_r;
  logic [7:0] luma_gain_low_byte_r;
  logic [7:0] u_gain_low_byte_r;
  logic       valid_r;

  wire logic hit_even_w = bus_i.addr == OFS_CTRL_EVEN;
  wire logic hit_luma_w = bus_i.addr == OFS_LUMA_GAIN_LO;
  wire logic hit_u_w    = bus_i.addr == OFS_U_GAIN_LO;
  wire logic hit_odd_w  = bus_i.addr == OFS_CTRL_ODD;

  // reserved bit is stored as written; zero writes are the caller's duty
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ctrl_even_r          <= RST_CTRL;
      ctrl_odd_r           <= RST_CTRL;
      luma_gain_low_byte_r <= RST_LUMA_GAIN_LO;
      u_gain_low_byte_r    <= RST_U_GAIN_LO;
    end else if (bus_i.write) begin
      if (hit_even_w) begin
        ctrl_even_r <= bus_i.wdata;
      end else if (hit_odd_w) begin
        ctrl_odd_r <= bus_i.wdata;
      end else if (hit_luma_w) begin
        luma_gain_low_byte_r <= bus_i.wdata;
      end else if (hit_u_w) begin
        u_gain_low_byte_r <= bus_i.wdata;
      end
    end
  end

  wire logic [7:0] rd_w = hit_even_w ? ctrl_even_r :
                          hit_odd_w  ? ctrl_odd_r :
                          hit_luma_w ? luma_gain_low_byte_r :
                          hit_u_w    ? u_gain_low_byte_r : 8'h00;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_o <= 8'h00;
    end else if (bus_i.read) begin
      rdata_o <= rd_w;
    end
  end

  wire logic [7:0] ctrl_act_w = odd_field_i ? ctrl_odd_r : ctrl_even_r;

  vlca_ctrl_t ctrl_w;
  assign ctrl_w.luma_notch_disable  = ctrl_act_w[BIT_NOTCH_DIS];
  assign ctrl_w.luma_decim_disable  = ctrl_act_w[BIT_DECIM_DIS];
  assign ctrl_w.chroma_order_invert = ctrl_act_w[BIT_CHROMA_INV];
  assign ctrl_w.luma_gain           = {ctrl_act_w[BIT_LUMA_TOP], luma_gain_low_byte_r};
  assign ctrl_w.u_gain_value        = {ctrl_act_w[BIT_U_TOP], u_gain_low_byte_r};
  assign ctrl_w.v_gain_value        = {ctrl_act_w[BIT_V_TOP], v_gain_low_byte_i};

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ctrl_o  <= '{1'b0, 1'b1, 1'b0, LUMA_UNITY, U_UNITY, V_UNITY};
      valid_r <= 1'b0;
    end else begin
      ctrl_o  <= ctrl_w;
      valid_r <= pix_valid_i;
    end
  end
  assign pix_valid_o = valid_r;

  vlca_gain_mul #(.PIX_W(PIX_W), .GAIN_W(GAIN_W), .UNITY(LUMA_UNITY)) u_luma (
    .clk_i    (clk_i),
    .reset_i  (reset_i),
    .sample_i (pix_i.y),
    .gain_i   (ctrl_w.luma_gain),
    .sample_o (pix_o.y)
  );

  vlca_gain_mul #(.PIX_W(PIX_W), .GAIN_W(GAIN_W), .UNITY(U_UNITY)) u_ugain (
    .clk_i    (clk_i),
    .reset_i  (reset_i),
    .sample_i (pix_i.u),
    .gain_i   (ctrl_w.u_gain_value),
    .sample_o (pix_o.u)
  );

  vlca_gain_mul #(.PIX_W(PIX_W), .GAIN_W(GAIN_W), .UNITY(V_UNITY)) u_vgain (
    .clk_i    (clk_i),
    .reset_i  (reset_i),
    .sample_i (pix_i.v),
    .gain_i   (ctrl_w.v_gain_value),
    .sample_o (pix_o.v)
  );
endmodule // vlca_adjust_regs

// ==== rtl/vlca_gain_mul.sv ====
`timescale 1ns/100ps
module vlca_gain_mul #(
  parameter int          PIX_W = 8,
  parameter int          GAIN_W = 9,
  parameter logic [8:0]  UNITY = 9'h0d8
) (
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  input  wire logic [PIX_W-1:0]  sample_i,
  input  wire logic [GAIN_W-1:0] gain_i,
  output logic      [PIX_W-1:0]  sample_o
);
  // unity is a fixed 9-bit code, so only a 9-bit gain can be served
  if (UNITY == 9'h000 || GAIN_W != 9) begin : g_bad_setup
    $error("vlca_gain_mul: bad gain setup");
  end

  // product over unity, saturated; a true divide keeps the printed gain ratios exact
  wire logic [PIX_W+GAIN_W-1:0] prod_w = sample_i * gain_i;
  wire logic [PIX_W+GAIN_W-1:0] quot_w = prod_w / {{PIX_W{1'b0}}, UNITY};
  wire logic                    ovf_w  = |quot_w[PIX_W+GAIN_W-1:PIX_W];
  wire logic [PIX_W-1:0]        sat_w  = ovf_w ? {PIX_W{1'b1}} : quot_w[PIX_W-1:0];

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sample_o <= '0;
    end else begin
      sample_o <= sat_w;
    end
  end
endmodule // vlca_gain_mul

// ==== rtl/vlca_pkg.sv ====
package vlca_pkg;
  localparam int          ADDR_W            = 8;
  localparam int          DATA_W            = 8;
  localparam int          GAIN_W            = 9;
  localparam int          PIX_W             = 8;
  localparam logic [7:0]  OFS_CTRL_EVEN     = 8'h2c;
  localparam logic [7:0]  OFS_LUMA_GAIN_LO  = 8'h30;
  localparam logic [7:0]  OFS_U_GAIN_LO     = 8'h34;
  localparam logic [7:0]  OFS_CTRL_ODD      = 8'hac;
  localparam logic [7:0]  RST_CTRL          = 8'h20;
  localparam logic [7:0]  RST_LUMA_GAIN_LO  = 8'hd8;
  localparam logic [7:0]  RST_U_GAIN_LO     = 8'hfe;
  localparam logic [7:0]  RST_V_GAIN_LO     = 8'hb4;
  localparam int          BIT_NOTCH_DIS     = 7;
  localparam int          BIT_DECIM_DIS     = 5;
  localparam int          BIT_CHROMA_INV    = 4;
  localparam int          BIT_RESERVED      = 3;
  localparam int          BIT_LUMA_TOP      = 2;
  localparam int          BIT_U_TOP         = 1;
  localparam int          BIT_V_TOP         = 0;
  localparam logic [8:0]  LUMA_UNITY        = 9'h0d8;
  localparam logic [8:0]  U_UNITY           = 9'h0fe;
  localparam logic [8:0]  V_UNITY           = 9'h0b4;

  typedef struct packed {
    logic       write;
    logic       read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } vlca_bus_req_t;

  typedef struct packed {
    logic [7:0] y;
    logic [7:0] u;
    logic [7:0] v;
  } vlca_pixel_t;

  typedef struct packed {
    logic       luma_notch_disable;
    logic       luma_decim_disable;
    logic       chroma_order_invert;
    logic [8:0] luma_gain;
    logic [8:0] u_gain_value;
    logic [8:0] v_gain_value;
  } vlca_ctrl_t;
endpackage

// ==== tb/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
  import vlca_pkg::*;
  logic          clk_i = 0, reset_i = 1, odd_field_i = 0, pix_valid_i = 0, pix_valid_o;
  logic [7:0]    v_gain_low_byte_i = 8'hb4, rdata_o;
  vlca_bus_req_t bus_i = '0;
  vlca_pixel_t   pix_i = '0, pix_o;
  vlca_ctrl_t    ctrl_o;
  int            err_total = 0, checks = 0;
  always #20 clk_i = ~clk_i;
  vlca_adjust_regs i_dut (.clk_i, .reset_i, .bus_i, .rdata_o, .odd_field_i, .v_gain_low_byte_i,
    .pix_valid_i, .pix_i, .pix_valid_o, .pix_o, .ctrl_o);
  task automatic chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(negedge clk_i) bus_i = '{1'b1, 1'b0, a, d};
    @(negedge clk_i) bus_i = '0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(negedge clk_i) bus_i = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk_i) bus_i = '0;
    chk(rdata_o === e, "read data");
  endtask
  // one sample in, one cycle latency out
  task automatic px(input vlca_pixel_t p, e);
    @(negedge clk_i) pix_i = p;
    pix_valid_i = 1;
    @(negedge clk_i) pix_valid_i = 0;
    chk(pix_o === e && pix_valid_o === 1'b1, "pixel");
  endtask
  task automatic cf(input logic [5:0] e);
    @(negedge clk_i);
    chk({ctrl_o.luma_notch_disable, ctrl_o.luma_decim_disable, ctrl_o.chroma_order_invert,
         ctrl_o.luma_gain[8], ctrl_o.u_gain_value[8], ctrl_o.v_gain_value[8]} === e, "control fields");
  endtask
  task automatic t_reset;
    rd(OFS_CTRL_EVEN, 8'h20);
    rd(OFS_CTRL_ODD, 8'h20);
    rd(OFS_LUMA_GAIN_LO, 8'hd8);
    rd(OFS_U_GAIN_LO, 8'hfe);
    rd(8'h38, 8'h00);
    px('{8'h64, 8'h64, 8'h64}, '{8'h64, 8'h64, 8'h64});
    $display("test reset done");
  endtask
  task automatic t_field;
    wr(OFS_CTRL_EVEN, 8'hb3);
    wr(OFS_CTRL_ODD, 8'h44);
    cf(6'h3b);
    px('{8'h20, 8'h40, 8'h40}, '{8'h20, 8'h80, 8'h9b});
    odd_field_i = 1;
    cf(6'h04);
    px('{8'h20, 8'h40, 8'h40}, '{8'h45, 8'h40, 8'h40});
    rd(OFS_CTRL_ODD, 8'h44);
    $display("test field done");
  endtask
  // gain changes land only after the control path settles
  task automatic t_gain;
    v_gain_low_byte_i = 8'h5a;
    wr(OFS_LUMA_GAIN_LO, 8'h80);
    wr(OFS_U_GAIN_LO, 8'h00);
    wr(OFS_CTRL_ODD, 8'h02);
    cf(6'h02);
    px('{8'h6c, 8'h7f, 8'h5a}, '{8'h40, 8'h80, 8'h2d});
    rd(OFS_LUMA_GAIN_LO, 8'h80);
    $display("test gain done");
  endtask
  task automatic print_verdict;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge clk_i);
    reset_i = 0;
    t_reset;
    t_field;
    t_gain;
    print_verdict;
  end
  initial begin
    repeat (2000) @(posedge clk_i);
    err_total++;
    print_verdict;
  end
endmodule // tb_top

// ==== tb/vlca_adjust_regs_sva.sv ====
`timescale 1ns/100ps
module vlca_adjust_regs_sva
  import vlca_pkg::*;
(
  input wire logic                   clk_i,
  input wire logic                   reset_i,
  input wire vlca_pkg::vlca_bus_req_t bus_i,
  input wire logic [7:0]             rdata_o,
  input wire logic                   odd_field_i,
  input wire logic [7:0]             v_gain_low_byte_i,
  input wire logic                   pix_valid_i,
  input wire vlca_pkg::vlca_pixel_t  pix_i,
  input wire logic                   pix_valid_o,
  input wire vlca_pkg::vlca_pixel_t  pix_o,
  input wire vlca_pkg::vlca_ctrl_t   ctrl_o
);
  wire [5:0] cb = {ctrl_o.luma_notch_disable, ctrl_o.luma_decim_disable, ctrl_o.chroma_order_invert,
                   ctrl_o.luma_gain[8], ctrl_o.u_gain_value[8], ctrl_o.v_gain_value[8]};
  wire       we = bus_i.write && bus_i.addr == OFS_CTRL_EVEN;
  wire       wo = bus_i.write && bus_i.addr == OFS_CTRL_ODD;
  function automatic logic [5:0] pick(logic [7:0] w);
    return {w[7], w[5:4], w[2:0]};
  endfunction
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  chk_ctrl_reset: assert property ($past(reset_i) |-> cb == 6'h10 && ctrl_o.u_gain_value == U_UNITY)
    else $error("ctrl not at defaults");
  chk_luma_low: assert property (bus_i.write && bus_i.addr == OFS_LUMA_GAIN_LO |=> ##1
    ctrl_o.luma_gain[7:0] == $past(bus_i.wdata, 2)) else $error("luma gain low wrong");
  chk_u_low: assert property (bus_i.write && bus_i.addr == OFS_U_GAIN_LO |=> ##1
    ctrl_o.u_gain_value[7:0] == $past(bus_i.wdata, 2)) else $error("u gain low wrong");
  chk_even_copy: assert property (we && !odd_field_i ##1 !odd_field_i |=>
    cb == pick($past(bus_i.wdata, 2))) else $error("even control wrong");
  chk_odd_copy: assert property (wo && odd_field_i ##1 odd_field_i |=>
    cb == pick($past(bus_i.wdata, 2))) else $error("odd control wrong");
  chk_v_low: assert property (!$past(reset_i) |-> ctrl_o.v_gain_value[7:0] == $past(v_gain_low_byte_i))
    else $error("v gain low wrong");
  chk_unmapped_read: assert property (bus_i.read && !bus_i.write && bus_i.addr == 8'h38 |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  chk_valid_delay: assert property (!$past(reset_i) |-> pix_valid_o == $past(pix_valid_i))
    else $error("valid delay wrong");
endmodule // vlca_adjust_regs_sva
bind vlca_adjust_regs vlca_adjust_regs_sva i_sva (.clk_i, .reset_i, .bus_i, .rdata_o, .odd_field_i,
  .v_gain_low_byte_i, .pix_valid_i, .pix_i, .pix_valid_o, .pix_o, .ctrl_o);
